// *** core/ruc_config_control.sv ***
// Configuration page selector with watchdog, status and APB register slave.
`include "ruc_consts.svh"
module ruc_config_control
   import ruc_pkg::*;
#(
   parameter int WDW = 20
) (
   // Clock and reset.
   input  wire logic          clock,
   input  wire logic          nrst,
   // APB slave.
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Mode strap pin, high selects local update mode.
   input  wire logic          localModePin,
   // Configuration source.
   output ruc_load_req_t      loadReq,
   input  wire ruc_load_rsp_t loadRspPin,
   // Device state.
   output logic               userMode,
   output logic               factoryRun
);
   ruc_state_t     state_r, state_nxt;
   logic [2:0]     page_r, page_nxt, curPage_r, curPage_nxt;
   logic           wdEn_r, wdEn_nxt;
   logic [WDW-1:0] wdTo_r, wdTo_nxt, wdCnt_r, wdCnt_nxt;
   logic [1:0]     cause_r, cause_nxt;
   logic           first_r, first_nxt, reload_r, reload_nxt;
   logic           armed_r, armed_nxt;
   logic           userMode_r, userMode_nxt, factoryRun_r, factoryRun_nxt;
   logic [31:0]    rd_r, rd_nxt;
   logic           rdy_r, rdy_nxt, err_r, err_nxt, start_r, start_nxt;
   logic [1:0]     modeSync_r, doneSync_r, errSync_r;
   logic           wrAcc, rdAcc, mapped, kick;

   // The strap keeps being sampled during reset, so the first load after release sees it.
   // Clearing these stages in reset would boot a local-mode device from the factory page.
   always_ff @(posedge clock) begin
      modeSync_r <= {modeSync_r[0], localModePin};
   end

   // Pins come from outside the clock domain, so two stages precede any use.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         doneSync_r <= 2'h0;
         errSync_r  <= 2'h0;
      end else begin
         doneSync_r <= {doneSync_r[0], loadRspPin.done};
         errSync_r  <= {errSync_r[0], loadRspPin.error};
      end
   end

   // Bus decode; the slave answers in the cycle after the first access cycle.
   assign wrAcc  = psel && penable && pwrite && !rdy_r;
   assign rdAcc  = psel && penable && !pwrite && !rdy_r;
   assign mapped = (paddr == `RUC_OFS_CTRL) || (paddr == `RUC_OFS_WDOG) ||
                   (paddr == `RUC_OFS_STATUS) || (paddr == `RUC_OFS_CMD);
   assign kick   = wrAcc && (paddr == `RUC_OFS_CMD) && pwdata[`RUC_CMD_KICK];

   // Next state of the loader, watchdog and register file.
   always_comb begin
      state_nxt   = state_r;
      page_nxt    = page_r;
      curPage_nxt = curPage_r;
      wdEn_nxt    = wdEn_r;
      wdTo_nxt    = wdTo_r;
      wdCnt_nxt   = wdCnt_r;
      cause_nxt   = cause_r;
      first_nxt   = first_r;
      reload_nxt  = reload_r;
      armed_nxt   = armed_r;
      start_nxt   = 1'b0;
      rdy_nxt     = 1'b0;
      err_nxt     = 1'b0;
      rd_nxt      = rd_r;
      // Register writes; the factory image names the page and watchdog.
      if (wrAcc) begin
         rdy_nxt = 1'b1;
         err_nxt = !mapped;
         if (paddr == `RUC_OFS_CTRL) begin
            page_nxt = pwdata[`RUC_CTRL_PAGE_LO +: 3];
            wdEn_nxt = pwdata[`RUC_CTRL_WDEN];
         end
         if (paddr == `RUC_OFS_WDOG) begin
            wdTo_nxt = pwdata[WDW-1:0];
         end
         if (paddr == `RUC_OFS_CMD && pwdata[`RUC_CMD_RELOAD]) begin
            reload_nxt = 1'b1;
         end
      end
      // Reads show live state; status is not cleared by reading.
      if (rdAcc) begin
         rdy_nxt = 1'b1;
         err_nxt = !mapped;
         rd_nxt  = 32'h0;
         case (paddr)
            `RUC_OFS_CTRL: begin
               rd_nxt[`RUC_CTRL_PAGE_LO +: 3] = page_r;
               rd_nxt[`RUC_CTRL_WDEN]         = wdEn_r;
               rd_nxt[`RUC_CTRL_LOCAL]        = modeSync_r[1];
            end
            `RUC_OFS_WDOG:   rd_nxt[WDW-1:0] = wdTo_r;
            `RUC_OFS_STATUS: begin
               rd_nxt[`RUC_STAT_CAUSE_LO +: 2] = cause_r;
               rd_nxt[`RUC_STAT_USER]          = (state_r == ST_USER);
               rd_nxt[`RUC_STAT_PAGE_LO +: 3]  = curPage_r;
            end
            default:         rd_nxt = 32'h0;
         endcase
      end
      case (state_r)
         ST_IDLE: begin
            // The first load in local mode goes straight to its only image, a pending remote reload to page_r, any other to page zero.
            if (first_r && modeSync_r[1]) begin
               curPage_nxt = `RUC_LOCAL_PAGE;
            end else begin
               curPage_nxt = `RUC_FACTORY_PAGE;
            end
            if (!first_r && !modeSync_r[1] && reload_r) begin
               curPage_nxt = page_r;
            end
            // Only a consumed request is cleared, so a reload written just now survives.
            if (reload_r) begin
               reload_nxt = 1'b0;
            end
            first_nxt  = 1'b0;
            start_nxt  = 1'b1;
            state_nxt  = ST_LOAD;
         end
         ST_LOAD: begin
            armed_nxt = 1'b0;
            state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            // The source keeps its answer as a level until the next start, so a level left
            // from the previous load is ignored until both synchronised lines read low.
            // A source that never drops its answer on a new start would hang here.
            if (!armed_r) begin
               armed_nxt = !errSync_r[1] && !doneSync_r[1];
            end else if (errSync_r[1]) begin
               cause_nxt   = `RUC_CAUSE_ERROR;
               reload_nxt  = 1'b0;
               state_nxt   = ST_IDLE;
            end else if (doneSync_r[1]) begin
               wdCnt_nxt = wdTo_r;
               state_nxt = ST_USER;
            end
         end
         ST_USER: begin
            if (kick) begin
               wdCnt_nxt = wdTo_r;
            end else if (wdEn_r && curPage_r != `RUC_FACTORY_PAGE && !modeSync_r[1]) begin
               wdCnt_nxt = wdCnt_r - 1'b1;
            end
            if (wdEn_r && curPage_r != `RUC_FACTORY_PAGE && !modeSync_r[1] &&
                !kick && wdCnt_r == '0) begin
               cause_nxt  = `RUC_CAUSE_WDOG;
               reload_nxt = 1'b0;
               state_nxt  = ST_IDLE;
            end else if (reload_r) begin
               // A reload from an application returns to factory; from factory, to page_r in remote mode and to factory in local mode.
               if (curPage_r != `RUC_FACTORY_PAGE) begin
                  reload_nxt = 1'b0;
                  cause_nxt  = `RUC_CAUSE_USER;
               end
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // Status outputs are taken from the next state so they change with the state itself.
      userMode_nxt   = (state_nxt == ST_USER);
      factoryRun_nxt = userMode_nxt && (curPage_nxt == `RUC_FACTORY_PAGE);
   end

   // Register stage; outputs come straight from these flip-flops.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_r   <= ST_IDLE;
         page_r    <= `RUC_FACTORY_PAGE;
         curPage_r <= `RUC_FACTORY_PAGE;
         wdEn_r    <= 1'b0;
         wdTo_r    <= WDW'(`RUC_WDOG_RESET);
         wdCnt_r   <= WDW'(`RUC_WDOG_RESET);
         cause_r   <= `RUC_CAUSE_NONE;
         first_r   <= 1'b1;
         reload_r  <= 1'b0;
         rd_r      <= 32'h0;
         rdy_r     <= 1'b0;
         err_r     <= 1'b0;
         start_r   <= 1'b0;
         armed_r      <= 1'b0;
         userMode_r   <= 1'b0;
         factoryRun_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         page_r    <= page_nxt;
         curPage_r <= curPage_nxt;
         wdEn_r    <= wdEn_nxt;
         wdTo_r    <= wdTo_nxt;
         wdCnt_r   <= wdCnt_nxt;
         cause_r   <= cause_nxt;
         first_r   <= first_nxt;
         reload_r  <= reload_nxt;
         rd_r      <= rd_nxt;
         rdy_r     <= rdy_nxt;
         err_r     <= err_nxt;
         start_r   <= start_nxt;
         armed_r      <= armed_nxt;
         userMode_r   <= userMode_nxt;
         factoryRun_r <= factoryRun_nxt;
      end
   end

   assign prdata        = rd_r;
   assign pready        = rdy_r;
   assign pslverr       = err_r;
   assign loadReq       = '{page: curPage_r, start: start_r};
   assign userMode      = userMode_r;
   assign factoryRun    = factoryRun_r;
endmodule

// *** core/ruc_consts.svh ***
// Constants for the remote update configuration controller.
// How it works
// - First power-up in remote mode loads the factory image at page 000.
// - Watchdog expiry records a watchdog cause, then reloads the factory image.
// - Watchdog is forced off while the factory image runs.
// - Failed or corrupt application load records the cause, then falls back.
// - Successful application load enters user mode and runs it.
// - Up to seven application pages may be selected besides the factory page.
// - Local mode loads its single application image directly at power-up.
`ifndef RUC_CONSTS_SVH
`define RUC_CONSTS_SVH
`define RUC_OFS_CTRL     12'h000
`define RUC_OFS_WDOG     12'h004
`define RUC_OFS_STATUS   12'h008
`define RUC_OFS_CMD      12'h00c
`define RUC_CTRL_PAGE_LO 0
`define RUC_CTRL_WDEN    4
`define RUC_CTRL_LOCAL   8
`define RUC_STAT_CAUSE_LO 0
`define RUC_STAT_USER     2
`define RUC_STAT_PAGE_LO  8
`define RUC_CMD_KICK     0
`define RUC_CMD_RELOAD   1
`define RUC_FACTORY_PAGE 3'h0
`define RUC_LOCAL_PAGE   3'h1
`define RUC_WDOG_RESET   20'hfffff
`define RUC_CAUSE_NONE   2'h0
`define RUC_CAUSE_ERROR  2'h1
`define RUC_CAUSE_WDOG   2'h2
`define RUC_CAUSE_USER   2'h3
`endif

// *** core/ruc_pkg.sv ***
// Types for the remote update configuration controller.
package ruc_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_WAIT, ST_USER} ruc_state_t;
   typedef struct packed {
      logic [2:0] page;
      logic       start;
   } ruc_load_req_t;
   typedef struct packed {
      logic       done;
      logic       error;
   } ruc_load_rsp_t;
endpackage

// *** tb/ruc_cfg_src.sv ***
// Behavioural paged configuration source.
module ruc_cfg_src
   import ruc_pkg::*;
#(
   parameter logic [2:0] BAD_PAGE = 3'h7
) (
   // Clock and reset.
   input  wire logic          clock,
   input  wire logic          nrst,
   // Load link.
   input  wire ruc_load_req_t loadReq,
   output ruc_load_rsp_t      loadRsp
);
   timeunit 1ns;
   timeprecision 1ps;
   // Page zero holds the factory image and is only ever read here, never rewritten.
   // A parallel host in place of this model decodes the same three-bit page code.
   int unsigned delay;
   // A request drops the old answer; higher pages answer more slowly.
   always @(posedge clock) begin
      if (!nrst || loadReq.start) begin
         loadRsp <= '0;
         delay   <= 3 + 4 * loadReq.page;
      end else if (delay == 1) begin
         loadRsp.done  <= (loadReq.page != BAD_PAGE);
         loadRsp.error <= (loadReq.page == BAD_PAGE);
         delay         <= 0;
      end else if (delay > 1) begin
         delay <= delay - 1;
      end
   end
endmodule

// *** tb/ruc_config_control_sva.sv ***
// Port checker for the configuration page selector.
module ruc_config_control_sva
   import ruc_pkg::*;
(
   // Clock and bus.
   input wire logic          clock,
   input wire logic          nrst,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic          pslverr,
   // Load link and state.
   input wire logic          localModePin,
   input wire ruc_load_req_t loadReq,
   input wire ruc_load_rsp_t loadRspPin,
   input wire logic          userMode,
   input wire logic          factoryRun
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, masked while in reset.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   ready_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("no ready");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("lone err");
   start_pulse_a: assert property (loadReq.start |=> !loadReq.start) else $error("start held");
   remote_boot_a: assert property ($rose(nrst) && !localModePin |->
      ##[0:4] (loadReq.start && loadReq.page == 3'h0)) else $error("no factory boot");
   local_boot_a: assert property ($rose(nrst) && localModePin |->
      ##[0:4] (loadReq.start && loadReq.page == 3'h1)) else $error("no local boot");
   factory_page_a: assert property (factoryRun |-> loadReq.page == 3'h0)
      else $error("factory page");
   user_entry_a: assert property ($rose(loadRspPin.done) |-> ##[1:6] userMode)
      else $error("no user mode");
   error_fallback_a: assert property ($rose(loadRspPin.error) |->
      ##[1:6] (loadReq.start && loadReq.page == 3'h0)) else $error("no fallback");
   // Main scenarios.
   cover property (userMode && !factoryRun);
   cover property (pslverr);
   cover property ($rose(loadRspPin.error));
endmodule
bind ruc_config_control ruc_config_control_sva ruc_config_control_sva_i (.clock(clock),
   .nrst(nrst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .localModePin(localModePin), .loadReq(loadReq), .loadRspPin(loadRspPin),
   .userMode(userMode), .factoryRun(factoryRun));

// *** tb/ruc_config_control_tb.sv ***
// Bench for the configuration page selector.
module ruc_config_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ruc_pkg::*;
   logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, localModePin = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdData;
   logic pready, pslverr, userMode, factoryRun, rdErr;
   ruc_load_req_t loadReq;
   ruc_load_rsp_t loadRsp;
   int n_errors = 0, checked = 0, cycles = 0;
   ruc_config_control ruc_config_control_i (.clock(clock), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .localModePin(localModePin), .loadReq(loadReq),
      .loadRspPin(loadRsp), .userMode(userMode), .factoryRun(factoryRun));
   ruc_cfg_src ruc_cfg_src_i (.clock(clock), .nrst(nrst), .loadReq(loadReq), .loadRsp(loadRsp));
   // Clock and hang guard.
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (n_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; a gap cycle keeps two requests apart.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic waitFor(input logic fac);
      int i;
      repeat (3) @(posedge clock);
      for (i = 0; i < 400 && !(userMode === 1'b1 && factoryRun === fac); i++) @(posedge clock);
      check(32'(i < 400), 32'h1, "load wait");
   endtask
   task automatic status(input logic [2:0] page, input logic [1:0] cause);
      apb(1'b0, 12'h008, 32'h0);
      check(32'(rdData[10:8]), 32'(page), "page");
      check(32'(rdData[1:0]), 32'(cause), "cause");
      check(32'(rdData[2]), 32'h1, "user bit");
   endtask
   // Remote sequence, then a second reset into local mode.
   initial begin
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      waitFor(1'b1);
      status(3'h0, 2'h0);
      apb(1'b0, 12'h004, 32'h0);
      check(rdData, 32'h000fffff, "timeout reset");
      apb(1'b0, 12'h010, 32'h0);
      check(32'(rdErr), 32'h1, "unmapped error");
      check(rdData, 32'h0, "unmapped data");
      for (int p = 1; p < 7; p++) begin
         apb(1'b1, 12'h000, 32'(p));
         apb(1'b1, 12'h00c, 32'h2);
         waitFor(1'b0);
         status(3'(p), (p == 1) ? 2'h0 : 2'h3);
         apb(1'b1, 12'h00c, 32'h2);
         waitFor(1'b1);
         status(3'h0, 2'h3);
      end
      apb(1'b1, 12'h000, 32'h7);
      apb(1'b1, 12'h00c, 32'h2);
      waitFor(1'b1);
      status(3'h0, 2'h1);
      apb(1'b1, 12'h004, 32'd30);
      apb(1'b1, 12'h000, 32'h15);
      apb(1'b0, 12'h000, 32'h0);
      check(rdData, 32'h15, "control");
      repeat (60) @(posedge clock);
      check(32'(factoryRun), 32'h1, "factory kept");
      apb(1'b1, 12'h00c, 32'h2);
      waitFor(1'b0);
      repeat (5) apb(1'b1, 12'h00c, 32'h1);
      check(32'(factoryRun), 32'h0, "kicked app");
      waitFor(1'b1);
      status(3'h0, 2'h2);
      nrst         <= 1'b0;
      localModePin <= 1'b1;
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      waitFor(1'b0);
      status(3'h1, 2'h0);
      apb(1'b0, 12'h000, 32'h0);
      check(rdData, 32'h100, "local strap");
      finish_test();
   end
endmodule
